// ---- fcb_branch.sv ----
// flag conditional branch sequencer: program counter, flags and timing
//
// Behaviour
// - with the half-carry-set branch and H at 1, the pc becomes pc plus k plus one.
// - with the half-carry-clear branch and H at 0, the pc becomes pc plus k plus one.
// - with the transfer-bit-set branch and T at 1, the pc becomes pc plus k plus one.
// - with the transfer-bit-clear branch and T at 0, the pc becomes pc plus k plus one.
// - none of the four branches changes any status flag, taken or not.
// - each of the four branches completes in one or two clock cycles.
`timescale 1ns/1ps
`include "fcb_params.svh"

module fcb_branch
  import fcb_pkg::*;
#(
  parameter int PC_W = 16 // program counter width in bits; the pc counts words
)
(
  input wire logic clock_i, // core clock, 250 MHz
  input wire logic rst_n_i, // asynchronous reset, active low
  input wire logic ce_i, // clock enable, freezes all state but the reset synchroniser when low
  input wire logic instr_valid_i, // opcode word offered
  input wire logic [15:0] instr_i, // opcode word
  input wire logic sreg_load_i, // other instructions write the flags
  input wire logic [7:0] sreg_din_i, // flag value to write
  output logic instr_ready_o, // an opcode can be accepted this cycle
  output logic [PC_W-1:0] pc_o, // program counter
  output logic [7:0] sreg_o, // status flags
  output logic taken_o, // pulse: branch taken
  output logic done_o, // pulse: a branch instruction completed
  output logic flush_o // pulse: fetched word is discarded
);

  logic rst_sync1;
  logic rst_n;
  fcb_state_e state;
  logic [PC_W-1:0] pc;
  logic [7:0] sreg;
  fcb_kind_e kind;
  logic cond;
  logic [6:0] offset;
  logic [PC_W-1:0] offset_ext;
  logic accept;
  logic is_branch;
  logic take;

  // sign extension of the word offset
  function automatic logic [PC_W-1:0] sext_k(input logic [6:0] k);
    sext_k = {{(PC_W-7){k[6]}}, k};
  endfunction : sext_k

  // reset release through two flops; assert stays asynchronous
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync1 <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_sync1 <= 1'h1;
      rst_n <= rst_sync1;
    end
  end

  // opcode decode and flag test
  fcb_decode u_decode (
    .instr_i(instr_i),
    .sreg_i(sreg),
    .kind_o(kind),
    .cond_o(cond),
    .offset_o(offset)
  );

  assign offset_ext = sext_k(offset);
  assign accept = instr_valid_i && (state == FCB_ST_EXEC);
  assign is_branch = (kind != FCB_KIND_NONE);
  assign take = accept && is_branch && cond;

  // sequencer: a taken branch spends one extra cycle on the refill
  // one or two cycles
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= FCB_ST_EXEC;
    end else if (ce_i) begin
      case (state)
        FCB_ST_EXEC: begin
          if (take) begin
            state <= FCB_ST_REFILL;
          end
        end
        FCB_ST_REFILL: begin
          state <= FCB_ST_EXEC;
        end
        default: begin
          state <= FCB_ST_EXEC;
        end
      endcase
    end
  end

  // program counter: relative jump when taken, else the next word
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_W'(`FCB_PC_RESET);
    end else if (ce_i && accept) begin
      if (take) begin
        pc <= pc + offset_ext + PC_W'(1);
      end else begin
        pc <= pc + PC_W'(1);
      end
    end
  end

  // status flags: only a load from elsewhere writes them
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sreg <= `FCB_SREG_RESET;
    end else if (ce_i) begin
      if (sreg_load_i) begin
        sreg <= sreg_din_i;
      end
    end
  end

  // event pulses, all registered so outputs come from flops
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      taken_o <= 1'h0;
      done_o <= 1'h0;
      flush_o <= 1'h0;
    end else if (ce_i) begin
      taken_o <= take;
      // completion lands at the end of the last cycle of the branch
      done_o <= (accept && is_branch && !cond) || (state == FCB_ST_REFILL);
      flush_o <= take;
    end
  end

  // output copies
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      instr_ready_o <= 1'h1;
    end else if (ce_i) begin
      instr_ready_o <= !take;
    end
  end

  assign pc_o = pc;
  assign sreg_o = sreg;

  // taken half-carry-set branch lands on pc + k + 1
  property p_hs_target;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && take && kind == FCB_KIND_HS) |=>
      (pc == $past(pc) + $past(offset_ext) + PC_W'(1));
  endproperty
  a_hs_target: assert property (p_hs_target)
    else $error("half-carry-set branch missed its target");

  // half-carry-clear branch follows the H flag, taken only at zero
  property p_hc_target;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && accept && kind == FCB_KIND_HC) |=>
      (pc == ($past(sreg[`FCB_SREG_H_BIT]) ? $past(pc) + PC_W'(1)
                                           : $past(pc) + $past(offset_ext) + PC_W'(1)));
  endproperty
  a_hc_target: assert property (p_hc_target)
    else $error("half-carry-clear branch went to the wrong address");

  // transfer-bit-set branch follows the T flag
  property p_ts_target;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && accept && kind == FCB_KIND_TS) |=>
      (pc == ($past(sreg[`FCB_SREG_T_BIT]) ? $past(pc) + $past(offset_ext) + PC_W'(1)
                                           : $past(pc) + PC_W'(1)));
  endproperty
  a_ts_target: assert property (p_ts_target)
    else $error("transfer-bit-set branch went to the wrong address");

  // transfer-bit-clear branch taken only when T is zero
  property p_tc_taken;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && accept && kind == FCB_KIND_TC) |=>
      (taken_o == !$past(sreg[`FCB_SREG_T_BIT]));
  endproperty
  a_tc_taken: assert property (p_tc_taken)
    else $error("transfer-bit-clear branch decision wrong");

  // flags hold across any branch without a foreign load
  property p_flags_kept;
    @(posedge clock_i) disable iff (!rst_n)
    (accept && is_branch && !sreg_load_i) |=> $stable(sreg);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("a branch changed the status flags");

  // refill lasts exactly one enabled cycle
  property p_refill_one;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && state == FCB_ST_REFILL) |=> (state == FCB_ST_EXEC && instr_ready_o);
  endproperty
  a_refill_one: assert property (p_refill_one)
    else $error("branch took more than two cycles");

  // not taken: next opcode accepted at once; taken: one stall then ready
  property p_cycle_cost;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && accept && is_branch) |=>
      (instr_ready_o == !$past(cond)) && (done_o == !$past(cond));
  endproperty
  a_cycle_cost: assert property (p_cycle_cost)
    else $error("branch cycle count does not follow its outcome");

  // a taken branch raises the flush pulse together with the taken pulse
  property p_flush_pair;
    @(posedge clock_i) disable iff (!rst_n)
    (ce_i && take) |=> (flush_o && taken_o && !instr_ready_o);
  endproperty
  a_flush_pair: assert property (p_flush_pair)
    else $error("taken branch did not flush the fetched word");

endmodule : fcb_branch

// ---- fcb_decode.sv ----
// opcode decode and flag test for the four conditional branches
`timescale 1ns/1ps
`include "fcb_params.svh"

module fcb_decode
  import fcb_pkg::*;
(
  input wire logic [15:0] instr_i, // opcode word
  input wire logic [7:0] sreg_i, // current status flags
  output fcb_kind_e kind_o, // decoded branch kind
  output logic cond_o, // tested flag matches
  output logic [6:0] offset_o // signed word offset k
);

  logic half_carry;
  logic transfer_bit;
  logic is_cond;
  logic clr_form;
  logic [2:0] sel;

  // field extraction
  assign half_carry = sreg_i[`FCB_SREG_H_BIT];
  assign transfer_bit = sreg_i[`FCB_SREG_T_BIT];
  assign is_cond = (instr_i[`FCB_OP_TOP_HI:`FCB_OP_TOP_LO] == `FCB_OP_TOP_VAL);
  assign clr_form = instr_i[`FCB_OP_CLR_BIT];
  assign sel = instr_i[`FCB_OP_SEL_HI:`FCB_OP_SEL_LO];
  assign offset_o = instr_i[`FCB_OP_K_HI:`FCB_OP_K_LO];

  // kind and condition; other flag selects belong to sibling branches
  always_comb begin
    kind_o = FCB_KIND_NONE;
    cond_o = 1'h0;
    if (is_cond && sel == 3'(`FCB_SREG_H_BIT)) begin
      kind_o = clr_form ? FCB_KIND_HC : FCB_KIND_HS;
      cond_o = clr_form ? !half_carry : half_carry;
    end else if (is_cond && sel == 3'(`FCB_SREG_T_BIT)) begin
      kind_o = clr_form ? FCB_KIND_TC : FCB_KIND_TS;
      cond_o = clr_form ? !transfer_bit : transfer_bit;
    end
  end

endmodule : fcb_decode

// ---- fcb_params.svh ----
// constants for the flag conditional branch block
`ifndef FCB_PARAMS_SVH
`define FCB_PARAMS_SVH

// status register bit positions
`define FCB_SREG_H_BIT 5
`define FCB_SREG_T_BIT 6
`define FCB_SREG_RESET 8'h00

// conditional branch opcode layout: 1111 0Xkk kkkk ksss
`define FCB_OP_TOP_HI 15
`define FCB_OP_TOP_LO 11
`define FCB_OP_TOP_VAL 5'h1E
`define FCB_OP_CLR_BIT 10
`define FCB_OP_K_HI 9
`define FCB_OP_K_LO 3
`define FCB_OP_SEL_HI 2
`define FCB_OP_SEL_LO 0

// cycle figures of the branch
`define FCB_CYC_NOT_TAKEN 1
`define FCB_CYC_TAKEN 2

// reset values
`define FCB_PC_RESET 16'h0000

`endif

// ---- fcb_pkg.sv ----
// types shared by the flag conditional branch block
package fcb_pkg;

  // which of the four branches an opcode holds
  typedef enum logic [2:0] {
    FCB_KIND_NONE = 3'h0,
    FCB_KIND_HS = 3'h1,
    FCB_KIND_HC = 3'h2,
    FCB_KIND_TS = 3'h3,
    FCB_KIND_TC = 3'h4
  } fcb_kind_e;

  // sequencer states
  typedef enum logic [0:0] {
    FCB_ST_EXEC = 1'h0,
    FCB_ST_REFILL = 1'h1
  } fcb_state_e;

endpackage : fcb_pkg

// ---- flag_conditional_branch_tb_top.sv ----
// self-checking testbench for the flag conditional branch sequencer
`timescale 1ns/1ps
`include "fcb_params.svh"

module flag_conditional_branch_tb_top;
  logic clock_i, rst_n_i, ce_i, instr_valid_i, sreg_load_i;
  logic [15:0] instr_i;
  logic [7:0] sreg_din_i;
  logic instr_ready_o, taken_o, done_o, flush_o;
  logic [15:0] pc_o;
  logic [7:0] sreg_o;
  logic [15:0] m_pc;
  logic [7:0] m_sreg;
  int failures, check_count;

  fcb_branch #(.PC_W(16)) DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .sreg_load_i(sreg_load_i), .sreg_din_i(sreg_din_i),
    .instr_ready_o(instr_ready_o), .pc_o(pc_o), .sreg_o(sreg_o), .taken_o(taken_o),
    .done_o(done_o), .flush_o(flush_o));

  // 250 MHz core clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // only the four branches testing the H or T flag count as branches here
  function automatic logic is_branch(input logic [15:0] w);
    return (w[15:11] == `FCB_OP_TOP_VAL) &&
      (w[2:0] == 3'h5 || w[2:0] == 3'h6);
  endfunction : is_branch

  // set form branches on a one, clear form on a zero
  function automatic logic exp_taken(input logic [15:0] w, input logic [7:0] s);
    return is_branch(w) && (s[w[2:0]] == ~w[10]);
  endfunction : exp_taken

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // one word through the port; optional flag write and a frozen cycle before it is taken
  task automatic do_instr(input logic [15:0] w, input logic ld, input logic [7:0] din,
                          input logic stall);
    logic tk;
    logic [15:0] epc;
    tk = exp_taken(w, m_sreg);
    epc = tk ? m_pc + {{9{w[9]}}, w[9:3]} + 16'h0001 : m_pc + 16'h0001;
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    sreg_load_i <= ld;
    sreg_din_i <= din;
    ce_i <= ~stall;
    if (stall) begin
      @(posedge clock_i);
      ce_i <= 1'b1;
      #1;
      chk(pc_o, m_pc);
      chk(16'(done_o), 16'h0000);
    end
    @(posedge clock_i);
    // a taken branch keeps offering its word into the refill slot, where it must be ignored
    instr_valid_i <= tk;
    sreg_load_i <= 1'b0;
    #1;
    if (ld) m_sreg = din;
    chk(pc_o, epc);
    chk(16'(sreg_o), 16'(m_sreg));
    chk(16'(taken_o), 16'(tk));
    chk(16'(flush_o), 16'(tk));
    chk(16'(done_o), 16'(is_branch(w) && !tk));
    chk(16'(instr_ready_o), 16'(!tk));
    // taken branch finishes in the refill cycle; the held offer must not move the pc
    if (tk) begin
      @(posedge clock_i);
      instr_valid_i <= 1'b0;
      #1;
      chk(16'(done_o), 16'h0001);
      chk(16'(taken_o), 16'h0000);
      chk(16'(instr_ready_o), 16'h0001);
      chk(pc_o, epc);
      chk(16'(sreg_o), 16'(m_sreg));
    end
    m_pc = epc;
  endtask : do_instr

  // watchdog: the run needs a few thousand cycles at most
  initial begin
    repeat (40000) @(posedge clock_i);
    failures++;
    give_verdict();
  end

  initial begin
    logic [15:0] w;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    sreg_load_i = 1'b0;
    sreg_din_i = 8'h00;
    failures = 0;
    check_count = 0;
    m_pc = 16'h0000;
    m_sreg = 8'h00;
    void'($urandom(32'h4E9E53A9));
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // wait out the reset synchroniser before the first word
    repeat (3) @(posedge clock_i);
    // every kind with its flag at both levels, offsets at both extremes
    for (int i = 0; i < 16; i++) begin
      do_instr(16'h0000, 1'b1, (i[0] ? 8'hFF : 8'h00), 1'b0);
      // select field 5 tests the half-carry flag, 6 the transfer bit
      w = {5'h1E, i[1], (i[3] ? 7'h40 : 7'h3F), (i[2] ? 3'h6 : 3'h5)};
      do_instr(w, 1'b0, 8'h00, i[3]);
    end
    // flag write in the same cycle: the branch tests the old flags
    do_instr(16'h0000, 1'b1, 8'h20, 1'b0);
    do_instr(16'hF42D, 1'b1, 8'h00, 1'b0);
    // random mix of branches, other words, flag writes and frozen cycles
    for (int i = 0; i < 300; i++) begin
      w = {5'h1E, 1'($urandom), 7'($urandom), 1'b1, 2'($urandom_range(1, 2)) ^ 2'h3};
      if ($urandom_range(0, 4) == 0) w = 16'($urandom);
      do_instr(w, ($urandom_range(0, 3) == 0), 8'($urandom), ($urandom_range(0, 7) == 0));
    end
    give_verdict();
  end
endmodule : flag_conditional_branch_tb_top
